// >>> rtl/emp_pkg.sv
package emp_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] EMP_OFS_GLOBAL_CTRL = 5'h00; // mem_port_global_control
    localparam logic [4:0] EMP_OFS_DEV_CONFIG  = 5'h04; // device_config_word
    localparam logic [4:0] EMP_OFS_ACC_ADDR    = 5'h08; // byte address of next access
    localparam logic [4:0] EMP_OFS_ACC_WDATA   = 5'h0C; // write data of next access
    localparam logic [4:0] EMP_OFS_ACC_CMD     = 5'h10; // size and direction, write starts
    localparam logic [4:0] EMP_OFS_STATUS      = 5'h14; // busy, hold ack, decode error
    localparam logic [4:0] EMP_OFS_RDATA       = 5'h18; // data of last read access

    // field positions
    localparam int EMP_BIT_CLK_SRC   = 4;  // in device_config_word
    localparam int EMP_BIT_CLK_EN    = 5;  // in mem_port_global_control
    localparam int EMP_TYPE_LSB      = 8;  // two bits of memory type per space
    localparam int EMP_BIT_CMD_WRITE = 2;
    localparam int EMP_BIT_ST_BUSY   = 0;
    localparam int EMP_BIT_ST_BUS_HOLD_ACK  = 1;
    localparam int EMP_BIT_ST_ERR    = 2;
    localparam int EMP_BIT_ST_BREQ   = 3;

    // reset values: clock from internal divider, clock output running
    localparam logic [31:0] EMP_RST_GLOBAL_CTRL = 32'h0000_0020;
    localparam logic [31:0] EMP_RST_DEV_CONFIG  = 32'h0000_0000;

    // address decode: word address bits 31..28 choose the space
    localparam int         EMP_SPACE_MSB  = 31;
    localparam int         EMP_SPACE_LSB  = 28;
    localparam logic [1:0] EMP_SPACE_BASE = 2'h2; // spaces sit at 0x8..0xB
    localparam int         EMP_EA_LSB     = 2;    // lowest external address bit
    localparam int         EMP_EA_W       = 20;   // ext lines 2 up to 21
    localparam int         EMP_NUM_CE     = 4;

    typedef enum logic [1:0] {EMP_MEM_ASYNC, EMP_MEM_SDRAM, EMP_MEM_SSRAM, EMP_MEM_RSVD} emp_mem_t;
    typedef enum logic [1:0] {EMP_SZ_BYTE, EMP_SZ_HALF, EMP_SZ_WORD, EMP_SZ_RSVD} emp_size_t;

    // phase lengths of an external access, in core clocks
    localparam logic [3:0] EMP_SETUP_CYC  = 4'h1;
    localparam logic [3:0] EMP_STROBE_CYC = 4'h2;
    localparam logic [3:0] EMP_HOLD_CYC   = 4'h1;
    localparam int         EMP_CLK_DIV    = 2; // core clocks per half period of the divided clock
endpackage

// >>> rtl/emp_clk_sel.sv
// memory clock output: internal divided clock or synchronised external input, gated low
module emp_clk_sel #(
    parameter int DIV = emp_pkg::EMP_CLK_DIV
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic mem_clock_in_i,       // external clock source pin
    input  wire logic mem_clock_source_sel_i,
    input  wire logic mem_clock_out_enable_i,
    output logic      mem_clock_out_o
);
    import emp_pkg::*;

    typedef struct packed {
        logic [7:0] div_cnt;   // divider count
        logic       div_clk;   // internal_divided_clock
        logic [2:0] ext_sync;  // three-stage sampler of the pin
        logic       ext_clk;   // filtered copy of the pin
        logic       clk_out;   // registered pin drive
    } emp_clk_t;

    emp_clk_t st;
    emp_clk_t next_st;

    // divider, sampler and output select
    always_comb begin
        next_st          = st;
        next_st.ext_sync = {st.ext_sync[1:0], mem_clock_in_i};
        // only a level the two later stages agree on is taken
        if (st.ext_sync[1] == st.ext_sync[2]) begin
            next_st.ext_clk = st.ext_sync[2];
        end
        if (st.div_cnt == 8'(DIV - 1)) begin
            next_st.div_cnt = 8'h00;
            next_st.div_clk = ~st.div_clk;
        end else begin
            next_st.div_cnt = st.div_cnt + 8'h01;
        end
        if (!mem_clock_out_enable_i) begin
            next_st.clk_out = 1'b0;
        end else if (mem_clock_source_sel_i) begin
            next_st.clk_out = st.ext_clk;
        end else begin
            next_st.clk_out = st.div_clk;
        end
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign mem_clock_out_o = st.clk_out;
endmodule

// >>> rtl/emp_port.sv
// Overview of operation
// - space chosen from word address bits 28-31
// - only one chip enable per access
// - byte lanes from address low bits, size
// - clock source bit 4 picks internal/external
// - clock enable bit 5 low holds clock
// - three strobes reused per memory type
// - byte lanes double as sdram data mask
// - hold request answered by hold acknowledge
// - external address lines carry bits 2-21
module emp_port (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [4:0]               avs_address_i,     // byte address
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    input  wire logic                     mem_clock_in_i,
    output logic                          mem_clock_out_o,
    output logic [emp_pkg::EMP_NUM_CE-1:0] chip_enable_n_o,
    output logic      [3:0]               byte_lane_select_n_o,
    output logic [emp_pkg::EMP_EA_W-1:0]  ext_word_addr_o,
    input  wire logic [31:0]              ext_data_lines_i,
    output logic      [31:0]              ext_data_lines_o,
    output logic                          ext_data_lines_oe_o,
    output logic                          rd_col_addr_strobe_n_o, // read / column / address strobe
    output logic                          oe_row_strobe_n_o,      // output enable / row strobe
    output logic                          write_strobe_n_o,
    output logic                          mem_pins_oe_o,          // port drives its control pins
    input  wire logic                     async_ready_in_i,
    input  wire logic                     hold_req_i,
    output logic                          bus_hold_ack_o,
    output logic                          bus_request_out_o
);
    import emp_pkg::*;

    typedef enum {EMP_IDLE, EMP_HELD, EMP_SETUP, EMP_STROBE, EMP_HOLD} emp_state_t;

    typedef struct packed {
        logic [31:0] gctl;     // mem_port_global_control
        logic [31:0] dcfg;     // device_config_word
        logic [31:0] acc_addr;
        logic [31:0] acc_wdata;
        logic [2:0]  acc_cmd;
        logic        pending;  // accepted command waiting for the bus
        logic        dec_err;  // last command hit no space
        logic [31:0] rdata;
        logic        ack;      // avalon answer phase
        logic [31:0] avs_rd;
        logic [2:0]  hold_s;   // hold pin sampler
        logic        hold_f;   // filtered hold
        logic [2:0]  rdy_s;    // ready pin sampler
        logic        rdy_f;
        emp_state_t  state;
        logic [3:0]  cnt;      // phase counter
        logic [3:0]  ce_n;
        logic [3:0]  be_n;
        logic [19:0] ea;
        logic        s0_n;
        logic        s1_n;
        logic        s2_n;
        logic        d_oe;
    } emp_port_t;

    emp_port_t st;
    emp_port_t next_st;

    logic       acc_req;  // bus access in this cycle
    logic       space_ok; // address falls into one of the spaces
    logic [1:0] space;    // selected space
    emp_mem_t   mtype;    // memory type of that space
    logic       is_wr;

    // merge a write under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // active-low byte lanes for an address and size
    function automatic logic [3:0] lanes_n(input logic [1:0] a, input logic [1:0] sz);
        logic [3:0] on;
        case (sz)
            EMP_SZ_BYTE: on = 4'h1 << a;
            EMP_SZ_HALF: on = a[1] ? 4'hC : 4'h3;
            default:     on = 4'hF;
        endcase
        return ~on;
    endfunction

    assign acc_req  = avs_read_i | avs_write_i;
    // the four spaces sit at one fixed value of bits 31..30
    assign space_ok = (st.acc_addr[EMP_SPACE_MSB -: 2] == EMP_SPACE_BASE);
    assign space    = st.acc_addr[EMP_SPACE_LSB +: 2];
    assign mtype    = emp_mem_t'(st.gctl[EMP_TYPE_LSB + 2*space +: 2]);
    assign is_wr    = st.acc_cmd[EMP_BIT_CMD_WRITE];

    // bus slave, pin samplers and access sequencer
    always_comb begin
        next_st        = st;
        next_st.hold_s = {st.hold_s[1:0], hold_req_i};
        next_st.rdy_s  = {st.rdy_s[1:0], async_ready_in_i};
        if (st.hold_s[1] == st.hold_s[2]) begin
            next_st.hold_f = st.hold_s[2];
        end
        if (st.rdy_s[1] == st.rdy_s[2]) begin
            next_st.rdy_f = st.rdy_s[2];
        end

        // every request waits exactly one cycle, then completes
        next_st.ack = acc_req & ~st.ack;
        if (acc_req && !st.ack) begin
            if (avs_address_i == EMP_OFS_GLOBAL_CTRL) begin
                next_st.avs_rd = st.gctl;
            end else if (avs_address_i == EMP_OFS_DEV_CONFIG) begin
                next_st.avs_rd = st.dcfg;
            end else if (avs_address_i == EMP_OFS_ACC_ADDR) begin
                next_st.avs_rd = st.acc_addr;
            end else if (avs_address_i == EMP_OFS_ACC_WDATA) begin
                next_st.avs_rd = st.acc_wdata;
            end else if (avs_address_i == EMP_OFS_ACC_CMD) begin
                next_st.avs_rd = {29'h0000_0000, st.acc_cmd};
            end else if (avs_address_i == EMP_OFS_STATUS) begin
                next_st.avs_rd = {28'h000_0000, bus_request_out_o, st.dec_err,
                                  bus_hold_ack_o, (st.pending | (st.state != EMP_IDLE && st.state != EMP_HELD))};
            end else if (avs_address_i == EMP_OFS_RDATA) begin
                next_st.avs_rd = st.rdata;
            end else begin
                next_st.avs_rd = 32'h0000_0000; // unmapped reads zero
            end
        end
        // writes take effect at the completing edge
        if (avs_write_i && st.ack) begin
            if (avs_address_i == EMP_OFS_GLOBAL_CTRL) begin
                next_st.gctl = be_merge(st.gctl, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == EMP_OFS_DEV_CONFIG) begin
                next_st.dcfg = be_merge(st.dcfg, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == EMP_OFS_ACC_ADDR) begin
                next_st.acc_addr = be_merge(st.acc_addr, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == EMP_OFS_ACC_WDATA) begin
                next_st.acc_wdata = be_merge(st.acc_wdata, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == EMP_OFS_ACC_CMD && avs_byteenable_i[0]) begin
                // a command while one is in flight is dropped: no queue
                if (!st.pending && (st.state == EMP_IDLE || st.state == EMP_HELD)) begin
                    next_st.acc_cmd = avs_writedata_i[2:0];
                    next_st.pending = space_ok;
                    next_st.dec_err = ~space_ok;
                end
            end
        end

        case (st.state)
            EMP_IDLE: begin
                if (st.hold_f) begin
                    next_st.state = EMP_HELD;
                end else if (st.pending) begin
                    next_st.pending = 1'b0;
                    next_st.state   = EMP_SETUP;
                    next_st.cnt     = EMP_SETUP_CYC - 4'h1;
                    next_st.ce_n    = ~(4'h1 << space);
                    next_st.be_n    = lanes_n(st.acc_addr[1:0], st.acc_cmd[1:0]);
                    next_st.ea      = st.acc_addr[EMP_EA_LSB +: EMP_EA_W];
                    next_st.d_oe    = is_wr;
                    next_st.s1_n    = ~((mtype == EMP_MEM_SDRAM) | ((mtype == EMP_MEM_ASYNC) & ~is_wr));
                    next_st.s0_n    = ~(mtype == EMP_MEM_SSRAM);
                    next_st.s2_n    = ~((mtype == EMP_MEM_SSRAM) & is_wr);
                end
            end
            EMP_HELD: begin
                if (!st.hold_f) begin
                    next_st.state = EMP_IDLE;
                end
            end
            EMP_SETUP: begin
                if (st.cnt == 4'h0) begin
                    next_st.state = EMP_STROBE;
                    next_st.cnt   = EMP_STROBE_CYC - 4'h1;
                    next_st.s0_n  = ~((mtype == EMP_MEM_SDRAM) | ((mtype == EMP_MEM_ASYNC) & ~is_wr));
                    next_st.s1_n  = ~(((mtype == EMP_MEM_ASYNC) | (mtype == EMP_MEM_SSRAM)) & ~is_wr);
                    next_st.s2_n  = ~(((mtype == EMP_MEM_ASYNC) | (mtype == EMP_MEM_SDRAM)) & is_wr);
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            EMP_STROBE: begin
                // async memory may stretch the strobe with its ready pin
                if (st.cnt != 4'h0) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else if (mtype != EMP_MEM_ASYNC || st.rdy_f) begin
                    next_st.state = EMP_HOLD;
                    next_st.cnt   = EMP_HOLD_CYC - 4'h1;
                    next_st.s0_n  = 1'b1;
                    next_st.s1_n  = 1'b1;
                    next_st.s2_n  = 1'b1;
                    if (!is_wr) begin
                        next_st.rdata = ext_data_lines_i;
                    end
                end
            end
            default: begin // EMP_HOLD
                if (st.cnt == 4'h0) begin
                    next_st.state = EMP_IDLE;
                    next_st.ce_n  = 4'hF;
                    next_st.be_n  = 4'hF;
                    next_st.d_oe  = 1'b0;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st       <= '0;
            st.gctl  <= EMP_RST_GLOBAL_CTRL;
            st.dcfg  <= EMP_RST_DEV_CONFIG;
            st.state <= EMP_IDLE;
            st.ce_n  <= 4'hF;
            st.be_n  <= 4'hF;
            st.s0_n  <= 1'b1;
            st.s1_n  <= 1'b1;
            st.s2_n  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    emp_clk_sel u_clk_sel (
        .core_clk_i             (core_clk_i),
        .rst_i                  (rst_i),
        .mem_clock_in_i         (mem_clock_in_i),
        .mem_clock_source_sel_i (st.dcfg[EMP_BIT_CLK_SRC]),
        .mem_clock_out_enable_i (st.gctl[EMP_BIT_CLK_EN]),
        .mem_clock_out_o        (mem_clock_out_o)
    );

    assign avs_waitrequest_o      = acc_req & ~st.ack;
    assign avs_readdata_o         = st.avs_rd;
    assign chip_enable_n_o        = st.ce_n;
    assign byte_lane_select_n_o   = st.be_n;
    assign ext_word_addr_o        = st.ea;
    assign ext_data_lines_o       = st.acc_wdata;
    assign ext_data_lines_oe_o    = st.d_oe;
    assign rd_col_addr_strobe_n_o = st.s0_n;
    assign oe_row_strobe_n_o      = st.s1_n;
    assign write_strobe_n_o       = st.s2_n;
    assign bus_hold_ack_o         = (st.state == EMP_HELD);
    assign mem_pins_oe_o          = (st.state != EMP_HELD);
    assign bus_request_out_o      = (st.state == EMP_HELD) & st.pending;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_one_ce_only: assert property ($countones(~chip_enable_n_o) <= 1)
        else $error("more than one chip enable low");
    a_ce_idle_high: assert property (st.state == EMP_IDLE |-> chip_enable_n_o == 4'hF)
        else $error("chip enable low while idle");
    a_ce_decode: assert property (st.state == EMP_STROBE |-> !chip_enable_n_o[st.acc_addr[EMP_SPACE_LSB +: 2]])
        else $error("wrong chip enable for address");
    a_lane_decode: assert property (st.state == EMP_STROBE
        |-> byte_lane_select_n_o == lanes_n(st.acc_addr[1:0], st.acc_cmd[1:0]))
        else $error("byte lanes do not match address and size");
    a_ea_bits: assert property (st.state == EMP_SETUP |-> ext_word_addr_o == st.acc_addr[21:2])
        else $error("external address not bits 21..2");
    a_hold_grant: assert property (st.state == EMP_IDLE && st.hold_f |=> bus_hold_ack_o && !mem_pins_oe_o)
        else $error("hold not granted from idle");
    a_clk_gated: assert property (!st.gctl[EMP_BIT_CLK_EN] ##1 !st.gctl[EMP_BIT_CLK_EN] |-> !mem_clock_out_o)
        else $error("memory clock runs while disabled");
    a_clk_source: assert property (st.gctl[EMP_BIT_CLK_EN] && !st.dcfg[EMP_BIT_CLK_SRC]
        |=> mem_clock_out_o == $past(u_clk_sel.st.div_clk))
        else $error("memory clock not from divider");
    a_write_strobe: assert property (st.state == EMP_STROBE && mtype == EMP_MEM_ASYNC && is_wr
        |-> !write_strobe_n_o && rd_col_addr_strobe_n_o)
        else $error("async write strobes wrong");
    a_sdram_mask: assert property (st.state == EMP_STROBE && mtype == EMP_MEM_SDRAM
        |-> oe_row_strobe_n_o && !rd_col_addr_strobe_n_o
            && byte_lane_select_n_o == lanes_n(st.acc_addr[1:0], st.acc_cmd[1:0]))
        else $error("sdram column phase wrong");
endmodule

// >>> sim/emp_mem_model.sv
// external memory model: small word store, byte masked writes
module emp_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        slow_i,               // stretch the ready answer
    input  wire logic [3:0]  chip_enable_n_i,
    input  wire logic [3:0]  byte_lane_select_n_i,
    input  wire logic [19:0] ext_word_addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        rd_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    output logic      [31:0] rdata_o,
    output logic             ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [16] = '{default: 32'h0}; // only address lines 5..2 decoded, aliases above
    logic [31:0] last_q = 32'h0;               // last value driven
    logic [3:0]  wait_q = 4'h0;                // cycles a strobe has been low
    logic        sel;        // any chip enable active
    assign sel = (chip_enable_n_i != 4'hF);
    // read data once strobed and ready; released lines show the inverse
    assign rdata_o = (sel && ready_o && (!oe_n_i || !rd_n_i)) ? mem[ext_word_addr_i[3:0]] : ~last_q;
    // slow mode holds ready low for three strobe cycles
    assign ready_o = !slow_i || (wait_q >= 4'h3);
    // store and ready count
    always @(posedge core_clk_i) begin
        last_q <= rdata_o;
        wait_q <= (sel && !(rd_n_i && oe_n_i && we_n_i)) ? wait_q + 4'h1 : 4'h0;
        if (sel && !we_n_i) begin
            for (int b = 0; b < 4; b++) begin
                if (!byte_lane_select_n_i[b]) begin
                    mem[ext_word_addr_i[3:0]][8*b+:8] <= wdata_i[8*b+:8];
                end
            end
        end
    end
endmodule

// >>> sim/emp_port_tb.sv
module emp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import emp_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, mem_rdata, ext_data_lines_o, rd;
    logic        avs_waitrequest_o, mem_clock_out_o, ext_data_lines_oe_o, mem_pins_oe_o, mem_ready;
    logic        mem_clock_in_i = 1'b0;
    logic        hold_req_i = 1'b0;
    logic        slow = 1'b0;
    logic        ext_run = 1'b0;       // external clock runs
    logic        rd_n, oe_n, we_n, bus_hold_ack_o, bus_request_out_o, mon_multi;
    logic        mon_clr = 1'b0;
    logic [3:0]  chip_enable_n_o, byte_lane_select_n_o, mon_ce, mon_be;
    logic [19:0] ext_word_addr_o, mon_ea;
    logic [3:0]  mon_lo;               // seen: data drive, write, oe, read low
    int          n_fail = 0;
    int          n_checks = 0;
    int          ext_div = 0;

    always #50 core_clk_i = ~core_clk_i;

    emp_port u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .mem_clock_in_i(mem_clock_in_i), .mem_clock_out_o(mem_clock_out_o), .chip_enable_n_o(chip_enable_n_o),
        .byte_lane_select_n_o(byte_lane_select_n_o), .ext_word_addr_o(ext_word_addr_o),
        .ext_data_lines_i(mem_rdata), .ext_data_lines_o(ext_data_lines_o),
        .ext_data_lines_oe_o(ext_data_lines_oe_o), .rd_col_addr_strobe_n_o(rd_n), .oe_row_strobe_n_o(oe_n),
        .write_strobe_n_o(we_n), .mem_pins_oe_o(mem_pins_oe_o), .async_ready_in_i(mem_ready),
        .hold_req_i(hold_req_i), .bus_hold_ack_o(bus_hold_ack_o), .bus_request_out_o(bus_request_out_o));

    emp_mem_model u_mem (.core_clk_i(core_clk_i), .slow_i(slow), .chip_enable_n_i(chip_enable_n_o),
        .byte_lane_select_n_i(byte_lane_select_n_o), .ext_word_addr_i(ext_word_addr_o),
        .wdata_i(ext_data_lines_o), .rd_n_i(rd_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .rdata_o(mem_rdata), .ready_o(mem_ready));

    // pin monitor and external clock at a sixth of the core rate
    always @(posedge core_clk_i) begin
        ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
        if (ext_run && ext_div == 2) begin
            mem_clock_in_i <= ~mem_clock_in_i;
        end
        if (mon_clr) begin
            mon_lo <= 4'h0;
            mon_ce <= 4'hF;
            mon_multi <= 1'b0;
        end else if (chip_enable_n_o !== 4'hF) begin
            mon_ce <= chip_enable_n_o;
            mon_be <= byte_lane_select_n_o;
            mon_ea <= ext_word_addr_o;
            mon_lo <= mon_lo | {ext_data_lines_oe_o, ~{we_n, oe_n, rd_n}};
            if ($countones(~chip_enable_n_o) > 1) begin
                mon_multi <= 1'b1;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // launch one external access, poll busy until it ends
    task automatic acc(input logic [31:0] a, input logic [2:0] cmd, input logic [31:0] d);
        bus(1'b1, EMP_OFS_ACC_ADDR, a);
        bus(1'b1, EMP_OFS_ACC_WDATA, d);
        mon_clr <= 1'b1;
        bus(1'b1, EMP_OFS_ACC_CMD, {29'h0, cmd});
        mon_clr <= 1'b0;
        do bus(1'b0, EMP_OFS_STATUS, 32'h0); while (rd[EMP_BIT_ST_BUSY] !== 1'b0);
    endtask

    // count memory clock changes over 24 core cycles
    task automatic watch(output int tog, output logic hi);
        logic prev;
        tog = 0;
        hi = 1'b0;
        prev = mem_clock_out_o;
        repeat (24) begin
            @(posedge core_clk_i);
            tog += (mem_clock_out_o !== prev);
            hi |= (mem_clock_out_o === 1'b1);
            prev = mem_clock_out_o;
        end
    endtask

    task automatic t_reset();
        bus(1'b0, EMP_OFS_GLOBAL_CTRL, 32'h0);
        check(rd, EMP_RST_GLOBAL_CTRL, "clock enable default");
        bus(1'b0, EMP_OFS_DEV_CONFIG, 32'h0);
        check(rd, EMP_RST_DEV_CONFIG, "clock source default");
        bus(1'b0, 5'h1C, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check({28'h0, chip_enable_n_o}, 32'hF, "idle enables");
        check({29'h0, rd_n, oe_n, we_n}, 32'h7, "idle strobes");
    endtask

    task automatic t_clock();
        int tog;
        logic hi;
        watch(tog, hi);
        check(32'(tog > 4), 32'h1, "internal clock runs");
        bus(1'b1, EMP_OFS_GLOBAL_CTRL, 32'h0);
        repeat (4) @(posedge core_clk_i);
        watch(tog, hi);
        check({31'h0, hi}, 32'h0, "gated clock low");
        bus(1'b1, EMP_OFS_GLOBAL_CTRL, 32'h20);
        bus(1'b1, EMP_OFS_DEV_CONFIG, 32'h10);
        repeat (8) @(posedge core_clk_i);
        watch(tog, hi);
        check(32'(tog), 32'h0, "external source still");
        ext_run <= 1'b1;
        watch(tog, hi);
        check(32'(tog > 2), 32'h1, "external source runs");
        ext_run <= 1'b0;
        bus(1'b1, EMP_OFS_DEV_CONFIG, 32'h0);
    endtask

    // every space with every size, lane offset taken from the space number, async writes
    task automatic t_spaces();
        logic [31:0] a;
        logic [3:0]  be;
        for (int s = 0; s < 4; s++) begin
            for (int z = 0; z < 3; z++) begin
                a = {4'(8 + s), 28'h015_5550} | ((z == 0) ? 32'(s) : (z == 1) ? 32'(s & 2) : 32'h0);
                be = (z == 0) ? ~(4'h1 << a[1:0]) : (z == 1) ? ~(4'h3 << {a[1], 1'b0}) : 4'h0;
                acc(a, {1'b1, 2'(z)}, 32'hA5A5_A5A5);
                check({28'h0, mon_ce}, {28'h0, ~(4'h1 << s)}, "space enable");
                check({31'h0, mon_multi}, 32'h0, "single enable");
                check({12'h0, mon_ea}, {12'h0, a[21:2]}, "word address");
                check({28'h0, mon_be}, {28'h0, be}, "byte lanes");
                check({28'h0, mon_lo}, 32'hC, "async write strobes");
                check({28'h0, chip_enable_n_o}, 32'hF, "enables released");
            end
        end
    endtask

    task automatic t_data();
        acc(32'h8000_0010, 3'b110, 32'h1234_5678);
        acc(32'h8000_0011, 3'b100, 32'hABAB_ABAB);
        slow <= 1'b1;
        acc(32'h8000_0010, 3'b010, 32'h0);
        slow <= 1'b0;
        check({28'h0, mon_lo}, 32'h3, "async read strobes");
        bus(1'b0, EMP_OFS_RDATA, 32'h0);
        check(rd, 32'h1234_AB78, "masked byte write");
    endtask

    task automatic t_types();
        bus(1'b1, EMP_OFS_GLOBAL_CTRL, 32'h0000_2420);
        acc(32'h9000_0020, 3'b110, 32'h0F0F_0F0F);
        check({28'h0, mon_lo}, 32'hF, "sdram write strobes");
        check({28'h0, mon_be}, 32'h0, "sdram mask word");
        acc(32'h9000_0020, 3'b010, 32'h0);
        check({28'h0, mon_lo}, 32'h3, "sdram read strobes");
        acc(32'hA000_0020, 3'b010, 32'h0);
        check({30'h0, mon_lo[2], mon_lo[0]}, 32'h1, "sync sram address strobe");
        bus(1'b1, EMP_OFS_GLOBAL_CTRL, 32'h20);
        acc(32'h0000_0040, 3'b110, 32'h0);
        check({31'h0, rd[EMP_BIT_ST_ERR]}, 32'h1, "outside spaces flagged");
        check({28'h0, mon_ce}, 32'hF, "no enable outside spaces");
    endtask

    task automatic t_hold();
        hold_req_i <= 1'b1;
        do @(posedge core_clk_i); while (bus_hold_ack_o !== 1'b1);
        check({31'h0, bus_hold_ack_o}, 32'h1, "hold granted");
        check({31'h0, mem_pins_oe_o}, 32'h0, "pins released");
        bus(1'b1, EMP_OFS_ACC_ADDR, 32'h8000_0004);
        mon_clr <= 1'b1;
        bus(1'b1, EMP_OFS_ACC_CMD, 32'h6);
        mon_clr <= 1'b0;
        repeat (10) @(posedge core_clk_i);
        check({28'h0, mon_ce}, 32'hF, "no access while held");
        check({31'h0, bus_request_out_o}, 32'h1, "bus requested");
        hold_req_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        check({30'h0, bus_hold_ack_o, mem_pins_oe_o}, 32'h1, "hold released");
        check({28'h0, mon_ce}, 32'hE, "pending access done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: well above the test length
    initial begin
        repeat (30000) @(posedge core_clk_i);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_clock();
        t_spaces();
        t_data();
        t_types();
        t_hold();
        stop_test();
    end
endmodule
